//--- owhost_defines.vh
// Constants for the single-wire status-write host controller.
// Assumes a 25 MHz core clock; included by bare name.
`ifndef OWHOST_DEFINES_VH
`define OWHOST_DEFINES_VH
`define CLK_MHZ 25
// Times in microseconds, counts derived in cycles
`define RESET_LOW_US 480
`define RESET_LOW_CYC (`RESET_LOW_US * `CLK_MHZ)
`define PRESENCE_WAIT_US 480
`define PRESENCE_WAIT_CYC (`PRESENCE_WAIT_US * `CLK_MHZ)
`define PRESENCE_SAMPLE_CYC (70 * `CLK_MHZ)
`define STROBE_US 6
`define STROBE_CYC (`STROBE_US * `CLK_MHZ)
`define SAMPLE_CYC (15 * `CLK_MHZ)
`define SLOT_CYC (65 * `CLK_MHZ)
`define PROG_US 2500
`define PROG_CYC (`PROG_US * `CLK_MHZ)
// Command codes
`define CMD_SKIP_ID 8'hCC
`define CMD_STATUS_WRITE 8'h55
`define CMD_PROGRAM 8'h5A
// CRC polynomial x^8+x^5+x^4+1, reflected feedback constant
`define CRC_POLY 8'h8C
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

//--- data_fifo.v
// Small synchronous FIFO with valid/ready on both sides.
// Assumes a single clock, active-low async reset and a clock enable.
`timescale 1ns/10ps
module data_fifo #(
	parameter WIDTH = 8,
	parameter DEPTH = 16,
	parameter AW = 4
) (
	// Clocking
	input wire core_clk,
	input wire resetn,
	input wire clkEn,
	// Fill side
	input wire inValid,
	output wire inReady,
	input wire [WIDTH-1:0] inData,
	// Drain side
	output wire outValid,
	input wire outReady,
	output wire [WIDTH-1:0] outData
);
	reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage array
	reg [AW-1:0] wrPtr_q; // Write index
	reg [AW-1:0] rdPtr_q; // Read index
	reg [AW:0] count_q; // Fill level
	wire doWrite;
	wire doRead;

	assign inReady = (count_q != DEPTH[AW:0]);
	assign outValid = (count_q != {(AW+1){1'b0}});
	assign outData = mem[rdPtr_q];
	assign doWrite = clkEn & inValid & inReady;
	assign doRead = clkEn & outValid & outReady;

	// Storage writes, no reset needed for data
	always @(posedge core_clk)
	begin
		if (doWrite)
			mem[wrPtr_q] <= inData;
	end

	// Pointers and level
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wrPtr_q <= {AW{1'b0}};
			rdPtr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (doWrite)
				wrPtr_q <= wrPtr_q + 1'b1;
			if (doRead)
				rdPtr_q <= rdPtr_q + 1'b1;
			if (doWrite & ~doRead)
				count_q <= count_q + 1'b1;
			else if (doRead & ~doWrite)
				count_q <= count_q - 1'b1;
		end
	end
endmodule // data_fifo

//--- status_write_host.v
// Host controller that programs the status field of a single-wire OTP memory.
// Assumes one open-drain line with pull-up, sampled synchronous to core_clk,
// and an external switch that applies the programming voltage when progPulse is high.
`timescale 1ns/10ps
`include "owhost_defines.vh"
module status_write_host (
	// Clocking
	input wire core_clk,
	input wire resetn,
	input wire clkEn,
	// Job request: start strobe and start address
	input wire start,
	input wire [15:0] startAddr,
	// Data bytes to program, through the FIFO
	input wire dataValid,
	output wire dataReady,
	input wire [7:0] dataByte,
	// Single-wire pin
	input wire lineIn,
	output reg lineOut,
	output reg lineOen_n,
	output reg progPulse,
	// Status
	output reg busy,
	output reg done,
	output reg errNoPresence,
	output reg errCrc,
	output reg errVerify
);
	// States
	localparam S_IDLE = 4'd0, S_RST = 4'd1, S_PRES = 4'd2, S_TXB = 4'd3, S_RXB = 4'd4;
	localparam S_PROG = 4'd5, S_NEXT = 4'd6, S_CHKCRC = 4'd7, S_CHKVER = 4'd8;
	localparam S_PULL = 4'd9;
	// Byte phases of the sequence
	localparam P_SKIP = 3'd0, P_CMD = 3'd1, P_ALO = 3'd2, P_AHI = 3'd3, P_DAT = 3'd4;
	localparam P_CRC = 3'd5, P_PGM = 3'd6, P_VER = 3'd7;

	reg [3:0] state_q; // Main sequencer
	reg [2:0] phase_q; // Which byte of the sequence
	reg [23:0] timer_q; // Slot and pulse timer, large enough for reset and program
	reg [2:0] bitCnt_q; // Bit within byte
	reg [7:0] shift_q; // Byte being sent or received
	reg [7:0] crc_q; // Host CRC model
	reg [15:0] addr_q; // Current status address
	reg [7:0] dataCur_q; // Byte now being programmed
	reg firstByte_q; // First byte carries command CRC
	reg sawPresence_q; // Presence seen in window
	reg retry_q; // Resend the held byte after a failed attempt
	wire fifoValid;
	wire [7:0] fifoData;
	reg fifoPop;
	wire lineBit;
	wire [7:0] crcNext;

	assign lineBit = (state_q == S_TXB) ? shift_q[0] : 1'b0;
	// LFSR step, feedback at taps 4, 5, 8, data LSB first
	assign crcNext = (crc_q >> 1) ^ (((crc_q[0] ^ lineBit) ? `CRC_POLY : 8'h00));

	// Input buffer; a full FIFO stalls the data source
	data_fifo #(.WIDTH(8), .DEPTH(`FIFO_DEPTH), .AW(`FIFO_AW)) uFifo (
		.core_clk(core_clk),
		.resetn(resetn),
		.clkEn(clkEn),
		.inValid(dataValid),
		.inReady(dataReady),
		.inData(dataByte),
		.outValid(fifoValid),
		.outReady(fifoPop),
		.outData(fifoData)
	);

	// Pop when a byte is loaded for transmission
	always @*
	begin
		fifoPop = clkEn && (state_q == S_NEXT) && fifoValid && !progPulse && !retry_q;
	end

	// Main sequencer: all pin and status outputs are registered here
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state_q <= S_IDLE;
			phase_q <= P_SKIP;
			timer_q <= 24'h000000;
			bitCnt_q <= 3'd0;
			shift_q <= 8'h00;
			crc_q <= 8'h00;
			addr_q <= 16'h0000;
			dataCur_q <= 8'hFF;
			firstByte_q <= 1'b1;
			sawPresence_q <= 1'b0;
			retry_q <= 1'b0;
			lineOut <= 1'b0; // Drive value stays low; only the enable moves the wire
			lineOen_n <= 1'b1;
			progPulse <= 1'b0;
			busy <= 1'b0;
			done <= 1'b0;
			errNoPresence <= 1'b0;
			errCrc <= 1'b0;
			errVerify <= 1'b0;
		end
		else if (clkEn)
		begin
			done <= 1'b0;
			case (state_q)
				S_IDLE:
				begin
					// Line left high between jobs is a legal pause
					lineOen_n <= 1'b1;
					if (start)
					begin
						busy <= 1'b1;
						errNoPresence <= 1'b0;
						errCrc <= 1'b0;
						errVerify <= 1'b0;
						addr_q <= startAddr;
						retry_q <= 1'b0;
						firstByte_q <= 1'b1;
						timer_q <= 24'h000000;
						state_q <= S_RST;
					end
				end
				S_RST:
				begin
					// Hold low long enough to reset the device and abort any sequence
					lineOen_n <= 1'b0;
					timer_q <= timer_q + 1'b1;
					if (timer_q == `RESET_LOW_CYC) // Low for the full count, never short
					begin
						lineOen_n <= 1'b1;
						timer_q <= 24'h000000;
						sawPresence_q <= 1'b0;
						state_q <= S_PRES;
					end
				end
				S_PRES:
				begin
					// Look for the device pulling low as its presence answer
					timer_q <= timer_q + 1'b1;
					if (timer_q < `PRESENCE_SAMPLE_CYC * 3 && !lineIn)
						sawPresence_q <= 1'b1;
					if (timer_q == `PRESENCE_WAIT_CYC - 1)
					begin
						timer_q <= 24'h000000;
						if (!sawPresence_q)
						begin
							errNoPresence <= 1'b1;
							busy <= 1'b0;
							state_q <= S_IDLE;
						end
						else
						begin
							// Skip identifier first, then status write
							phase_q <= P_SKIP;
							shift_q <= `CMD_SKIP_ID;
							bitCnt_q <= 3'd0;
							state_q <= S_TXB;
						end
					end
				end
				S_TXB:
				begin
					// Write slot: strobe low, then hold low for 0 or release for 1
					timer_q <= timer_q + 1'b1;
					if (timer_q == 24'd0)
						lineOen_n <= 1'b0;
					else if (timer_q == `STROBE_CYC)
						lineOen_n <= shift_q[0] ? 1'b1 : 1'b0;
					else if (timer_q == `SLOT_CYC - 1)
					begin
						lineOen_n <= 1'b1;
						timer_q <= 24'h000000;
						if (phase_q != P_SKIP)
							crc_q <= crcNext;
						// Shift out least significant bit first
						shift_q <= {1'b0, shift_q[7:1]};
						bitCnt_q <= bitCnt_q + 1'b1;
						if (bitCnt_q == 3'd7)
							state_q <= S_PULL;
					end
				end
				S_RXB:
				begin
					// Read slot: short strobe, then sample the device's answer
					timer_q <= timer_q + 1'b1;
					if (timer_q == 24'd0)
						lineOen_n <= 1'b0;
					else if (timer_q == `STROBE_CYC)
						lineOen_n <= 1'b1;
					else if (timer_q == `SAMPLE_CYC)
						shift_q <= {lineIn, shift_q[7:1]}; // LSB arrives first
					else if (timer_q == `SLOT_CYC - 1)
					begin
						timer_q <= 24'h000000;
						bitCnt_q <= bitCnt_q + 1'b1;
						if (bitCnt_q == 3'd7)
							state_q <= (phase_q == P_CRC) ? S_CHKCRC : S_CHKVER;
					end
				end
				S_PULL:
				begin
					// Choose the next byte of the sequence after a sent byte
					bitCnt_q <= 3'd0;
					case (phase_q)
						P_SKIP:
						begin
							phase_q <= P_CMD;
							shift_q <= `CMD_STATUS_WRITE;
							crc_q <= 8'h00;
							state_q <= S_TXB;
						end
						P_CMD:
						begin
							phase_q <= P_ALO;
							shift_q <= addr_q[7:0];
							state_q <= S_TXB;
						end
						P_ALO:
						begin
							phase_q <= P_AHI;
							shift_q <= addr_q[15:8];
							state_q <= S_TXB;
						end
						P_AHI:
						begin
							phase_q <= P_DAT;
							state_q <= S_NEXT;
						end
						P_DAT:
						begin
							// Device answers CRC over command, address and data, or over the data byte seeded with the low address
							phase_q <= P_CRC;
							state_q <= S_RXB;
						end
						P_PGM:
						begin
							// Pulse length is the program pulse time
							progPulse <= 1'b1;
							timer_q <= 24'h000000;
							state_q <= S_PROG;
						end
						default:
							state_q <= S_IDLE;
					endcase
				end
				S_NEXT:
				begin
					// Fetch the next data byte; an empty FIFO waits with line idle for the first byte, ends the job after it
					if (retry_q)
					begin
						// Byte already left the FIFO; resend the held copy
						shift_q <= dataCur_q;
						bitCnt_q <= 3'd0;
						retry_q <= 1'b0;
						state_q <= S_TXB;
					end
					else if (fifoValid)
					begin
						shift_q <= fifoData;
						dataCur_q <= fifoData;
						bitCnt_q <= 3'd0;
						state_q <= S_TXB;
						if (!firstByte_q)
							crc_q <= addr_q[7:0]; // Preload with new low address byte
					end
					else if (!firstByte_q)
					begin
						busy <= 1'b0;
						done <= 1'b1;
						state_q <= S_IDLE;
					end
				end
				S_CHKCRC:
				begin
					// Compare device CRC with our own; device will not stop by itself
					if (shift_q != crc_q)
					begin
						errCrc <= 1'b1;
						firstByte_q <= 1'b1; // Restart carries the full command CRC
						retry_q <= 1'b1;
						timer_q <= 24'h000000;
						state_q <= S_RST;
					end
					else
					begin
						phase_q <= P_PGM;
						shift_q <= `CMD_PROGRAM;
						bitCnt_q <= 3'd0;
						state_q <= S_TXB;
					end
				end
				S_PROG:
				begin
					// Hold the program pulse, then read back eight bits
					timer_q <= timer_q + 1'b1;
					if (timer_q == `PROG_CYC - 1)
						progPulse <= 1'b0;
					if (timer_q == `PROG_CYC + `SLOT_CYC - 1)
					begin
						timer_q <= 24'h000000;
						phase_q <= P_VER;
						bitCnt_q <= 3'd0;
						state_q <= S_RXB;
					end
				end
				S_CHKVER:
				begin
					// Programmed value must equal old AND data; assume erased ones
					if (shift_q != dataCur_q)
					begin
						errVerify <= 1'b1;
						firstByte_q <= 1'b1;
						retry_q <= 1'b1;
						timer_q <= 24'h000000;
						state_q <= S_RST;
					end
					else
					begin
						// Device has moved to the next byte by now
						addr_q <= addr_q + 1'b1;
						firstByte_q <= 1'b0;
						phase_q <= P_DAT;
						state_q <= S_NEXT;
					end
				end
				default:
					state_q <= S_IDLE;
			endcase
		end
	end

endmodule // status_write_host

//--- swh_properties.sv
// Port checker for the status-write host controller.
// Assumes a 25 MHz core_clk; bound to every host instance.
`timescale 1ns/10ps
module swh_properties (
	// Clocking
	input wire core_clk,
	input wire resetn,
	input wire clkEn,
	// Job control
	input wire start,
	input wire busy,
	input wire done,
	// Line side
	input wire lineOut,
	input wire lineOen_n,
	input wire progPulse
);
	reg [15:0] lowCnt_q; // Cycles the host has held the line low
	reg [15:0] gapCnt_q; // Cycles since the host last pulled low
	reg [16:0] pulCnt_q; // Enabled cycles of the program pulse

	// Counters measure whole phases, too long for a repetition
	always @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			lowCnt_q <= 16'h0000;
			gapCnt_q <= 16'hFFFF;
			pulCnt_q <= 17'h00000;
		end
		else
		begin
			lowCnt_q <= lineOen_n ? 16'h0000 : lowCnt_q + {15'h0000, clkEn};
			gapCnt_q <= (!lineOen_n && lowCnt_q == 16'h0000) ? 16'h0001 :
				gapCnt_q + {15'h0000, gapCnt_q != 16'hFFFF};
			pulCnt_q <= progPulse ? pulCnt_q + {16'h0000, clkEn} : 17'h00000;
		end
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);

	a_drive_zero: assert property (lineOut == 1'b0)
		else $error("Line drive value is not low");
	a_low_length: assert property ($rose(lineOen_n) |->
		lowCnt_q inside {[150:152], [1623:1626], [12000:12002]})
		else $error("Low phase has a wrong length");
	a_slot_gap: assert property ($fell(lineOen_n) |-> gapCnt_q >= 16'd1624)
		else $error("Slots start too close together");
	a_pulse_len: assert property ($fell(progPulse) |-> pulCnt_q inside {[62499:62502]})
		else $error("Program pulse has a wrong length");
	a_pulse_released: assert property (progPulse |-> lineOen_n)
		else $error("Line pulled low during program pulse");
	a_pulse_rest: assert property ($fell(progPulse) |-> lineOen_n [*8])
		else $error("Verify read starts too early");
	a_start_reset: assert property (start && !busy && clkEn |-> ##[1:2] !lineOen_n)
		else $error("Reset low did not follow start");
	a_idle_quiet: assert property (!busy |-> lineOen_n && !progPulse)
		else $error("Line active while idle");
	a_done_once: assert property (done |=> !done && !busy)
		else $error("Done not a single pulse ending the job");
endmodule // swh_properties

bind status_write_host swh_properties chk (.core_clk(core_clk), .resetn(resetn),
	.clkEn(clkEn), .start(start), .busy(busy), .done(done), .lineOut(lineOut),
	.lineOen_n(lineOen_n), .progPulse(progPulse));

//--- otp_status_model.sv
// Behavioural status-field memory on the far side of the line.
// Assumes a resolved line level with pull-up and ns time units.
`timescale 1ns/10ps
module otp_status_model (
	// Line and programming voltage
	input wire lineLvl,
	input wire progPulse,
	input wire present,
	// Device pull-down
	output reg devLow
);
	reg [7:0] mem [0:7]; // Status bytes
	reg [15:0] addr; // Address counter
	reg [7:0] crc, sh, dat, tx; // CRC, shifter, data, reply
	reg [7:0] cmd; // Second-level command
	reg [63:0] rid; // Identifier, CRC in its top byte
	reg b, rd, arm; // Bit, read phase, pulse armed
	int ph, nb, nid; // Phase, bit count, identifier byte
	time t0; // Fall time of the slot

	function automatic [7:0] crcB(input [7:0] c, input [7:0] d);
		for (int i = 0; i < 8; i++)
			c = (d[i] ^ c[0]) ? (c >> 1) ^ 8'h8C : c >> 1;
		return c;
	endfunction

	task automatic clr; // Back to the start of a sequence
		ph = 0;
		nb = 0;
		nid = 0;
		rd = 0;
		arm = 0;
		crc = 8'h00;
		devLow = 0;
	endtask

	// Erased field, factory byte last
	initial
	begin
		for (int i = 0; i < 7; i++)
			mem[i] = 8'hFF;
		mem[7] = 8'h00;
		rid[55:0] = 56'h3A61C0DE4B275C; // Serial and family code; values are arbitrary
		crc = 8'h00;
		for (int i = 0; i < 7; i++)
			crc = crcB(crc, rid[8*i +: 8]);
		rid[63:56] = crc;
		clr;
	end

	// Take one bit; act on each whole byte
	task automatic step;
		sh = {b, sh[7:1]};
		nb = nb + 1;
		if (nb == 8)
		begin
			nb = 0;
			if (ph >= 1 && ph <= 4)
				crc = crcB(crc, sh);
			if (ph == 2)
				addr[7:0] = sh;
			if (ph == 3)
				addr[15:8] = sh;
			if (ph == 1)
				cmd = sh;
			if (ph == 4)
				dat = sh;
			if (ph == 10)
				nid = nid + 1;
			if (ph == 7)
			begin
				addr = addr + 1;
				crc = addr[7:0];
			end
			arm = (ph == 6 && sh == 8'h5A);
			case (ph)
				0: ph = (sh == 8'hCC) ? 1 : (sh == 8'h33) ? 10 : 9;
				1: ph = (sh == 8'h55 || sh == 8'hF0 || sh == 8'hAA || sh == 8'hC3 ||
					sh == 8'h0F) ? 2 : (sh == 8'h99) ? 11 : 9;
				3: ph = (cmd == 8'h55) ? 4 : 8; // Other commands read the CRC
				6: ph = (sh == 8'h5A) ? 7 : 9;
				7: ph = 4;
				9: ph = 9;
				10: ph = (nid == 8) ? 9 : 10;
				11: ph = 9;
				default: ph = ph + 1;
			endcase
			rd = (ph == 5 || ph >= 7);
			if (ph == 9)
				crc = 8'hFF;
		end
	endtask

	// Slot engine; waits on idle as long as needed
	always
	begin
		@(negedge lineLvl);
		t0 = $time;
		if (rd)
		begin
			tx = (ph == 7) ? mem[addr[2:0]] : (ph == 10) ? rid[8*nid +: 8] :
				(ph == 11) ? 8'h55 : crc;
			b = tx[nb];
			#1000 devLow = !b;
			#44000 devLow = 0;
		end
		else
			#30000 b = lineLvl;
		wait (lineLvl);
		if ($time - t0 > 120000)
		begin
			clr;
			#30000 devLow = present;
			#120000 devLow = 0;
		end
		else
			step;
	end

	// Zeros of the data clear bits at the end of the pulse
	always @(negedge progPulse)
		if (arm)
		begin
			mem[addr[2:0]] = mem[addr[2:0]] & dat;
			arm = 0;
		end
endmodule // otp_status_model

//--- tb.sv
// Self-checking bench for the status-write host controller.
// Assumes the checker and device model files compile first.
`timescale 1ns/10ps
module tb;
	reg core_clk = 1'b0; // 25 MHz
	reg resetn = 1'b0;
	reg clkEn = 1'b1;
	reg start = 1'b0;
	reg [15:0] startAddr = 16'h0000;
	reg dataValid = 1'b0;
	reg [7:0] dataByte = 8'h00;
	reg present = 1'b0; // Device answers a reset
	reg npSeen = 1'b0; // No-presence flag seen last cycle
	reg [7:0] d0, d1; // Bytes to program
	reg [15:0] a; // First status address
	reg [2:0] expQ[$]; // Expected error flags per job end
	wire dataReady, lineOut, lineOen_n, progPulse, busy, done;
	wire errNoPresence, errCrc, errVerify, devLow, lineLvl;
	int failures = 0;
	int checks = 0;
	int n;

	always #20 core_clk = !core_clk;
	// Pull-up line: low when either side pulls
	assign lineLvl = (lineOen_n === 1'b0) ? lineOut : !devLow;

	status_write_host DUT (.core_clk(core_clk), .resetn(resetn), .clkEn(clkEn),
		.start(start), .startAddr(startAddr), .dataValid(dataValid),
		.dataReady(dataReady), .dataByte(dataByte), .lineIn(lineLvl),
		.lineOut(lineOut), .lineOen_n(lineOen_n), .progPulse(progPulse), .busy(busy),
		.done(done), .errNoPresence(errNoPresence), .errCrc(errCrc),
		.errVerify(errVerify));
	otp_status_model dev (.lineLvl(lineLvl), .progPulse(progPulse), .present(present),
		.devLow(devLow));

	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp)
		begin
			failures++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Offer one byte; valid stays up for the caller to drop
	task automatic push(input logic [7:0] b);
		#2 dataValid = 1'b1;
		dataByte = b;
		@(negedge core_clk);
		for (n = 0; n < 99 && dataReady !== 1'b1; n++)
			@(negedge core_clk);
		@(posedge core_clk);
	endtask

	// One-cycle job request
	task automatic kick(input logic [15:0] sa);
		@(posedge core_clk);
		#2 start = 1'b1;
		startAddr = sa;
		@(posedge core_clk);
		#2 start = 1'b0;
	endtask

	// Each job end takes the oldest note off the queue
	always @(negedge core_clk)
	begin
		if (resetn && (done === 1'b1 || (errNoPresence === 1'b1 && !npSeen)))
			check(8'({errNoPresence, errCrc, errVerify}), 8'(expQ.pop_front()));
		npSeen <= (errNoPresence === 1'b1);
	end

	initial
	begin
		n = $urandom(32'h77d3);
		repeat (10) @(posedge core_clk);
		#2 resetn = 1'b1;
		@(posedge core_clk);
		// Fill until the buffer refuses, nobody on the line
		repeat (16) push(8'($urandom));
		repeat (4) @(negedge core_clk);
		check(8'(dataReady), 8'h00);
		@(posedge core_clk);
		#2 dataValid = 1'b0;
		expQ.push_back(3'b100);
		kick(16'h0000);
		for (n = 0; n < 30000 && errNoPresence !== 1'b1; n++)
			@(posedge core_clk);
		repeat (2) @(negedge core_clk);
		check(8'({busy, lineOen_n, progPulse}), 8'h02);
		$display("Test 1 done");
		// Second reset empties the buffer; then a two-byte job
		@(posedge core_clk);
		#2 resetn = 1'b0;
		@(posedge core_clk);
		#2 resetn = 1'b1;
		check(8'({dataReady, busy, lineOen_n}), 8'h05);
		present = 1'b1;
		d0 = 8'($urandom);
		d1 = 8'($urandom);
		a = 16'(1 + $urandom % 5); // Keeps both bytes below the factory byte
		@(posedge core_clk);
		push(d0);
		push(d1);
		#2 dataValid = 1'b0;
		expQ.push_back(3'b000);
		kick(a);
		// Freeze mid-pulse, the line idle; nothing may be lost
		wait (progPulse === 1'b1);
		@(posedge core_clk);
		#2 clkEn = 1'b0;
		repeat (500) @(posedge core_clk);
		#2 clkEn = 1'b1;
		for (n = 0; n < 500000 && done !== 1'b1; n++)
			@(negedge core_clk);
		check(8'(done), 8'h01);
		@(posedge core_clk);
		check(8'(expQ.size()), 8'h00);
		check(dev.mem[a], d0);
		check(dev.mem[a + 16'h0001], d1);
		check(dev.mem[a - 16'h0001], 8'hFF);
		check(dev.mem[7], 8'h00);
		$display("Test 2 done");
		report_and_stop;
	end

	// Both jobs need about 350000 cycles
	initial
	begin
		repeat (600000) @(posedge core_clk);
		failures++;
		$display("Watchdog expired");
		report_and_stop;
	end
endmodule // tb
